//--- ipr_defs.svh
// register offsets, field layout and reset values of the priority block
`ifndef IPR_DEFS_SVH
`define IPR_DEFS_SVH

`define IPR_NUM_REGS      5
`define IPR_NUM_SLOTS     20
`define IPR_NUM_SRC       18
`define IPR_FIELD_W       3
`define IPR_SLOTS_PER_REG 4
`define IPR_SLOT_STRIDE   4
`define IPR_TOP_LSB       12

`define IPR_IDX_PRIO0     3'h0
`define IPR_IDX_PRIO1     3'h1
`define IPR_IDX_PRIO2     3'h2
`define IPR_IDX_PRIO3     3'h3
`define IPR_IDX_PRIO4     3'h4
`define IPR_IDX_ENABLE    3'h5
`define IPR_IDX_PENDING   3'h6

`define IPR_MASK_FULL     16'h7777
`define IPR_MASK_REG3     16'h0777
`define IPR_MASK_REG4     16'h7077
`define IPR_FIELD_RST     16'h4444
`define IPR_ENABLE_RST    18'h00000

`define IPR_LEVEL_OFF     3'h0
`define IPR_LEVEL_MIN     3'h1
`define IPR_LEVEL_MAX     3'h7

`endif

//--- ipr_pkg.sv
// types shared by the priority register block
package ipr_pkg;
	typedef logic [2:0]  ipr_level_t;
	typedef logic [15:0] ipr_word_t;
	typedef logic [17:0] ipr_src_vec_t;
endpackage : ipr_pkg

//--- ipr_prio_if.sv
// carrier between the register file and the level decoder
`timescale 1ns/1ps
interface ipr_prio_if;
	ipr_pkg::ipr_level_t   field [18];
	ipr_pkg::ipr_src_vec_t enable;
	ipr_pkg::ipr_src_vec_t src;
	ipr_pkg::ipr_level_t   level [18];
	ipr_pkg::ipr_src_vec_t req;

	modport regs (output field, output enable, output src, input level, input req);
	modport dec  (input field, input enable, input src, output level, output req);
endinterface : ipr_prio_if

//--- ipr_level_dec.sv
// turns stored priority fields into levels and gated requests
`timescale 1ns/1ps
`include "ipr_defs.svh"
module ipr_level_dec (
	input  wire logic I_CLK,
	input  wire logic I_RSTN,
	ipr_prio_if.dec   bus
);
	genvar g;

	generate
		for (g = 0; g < `IPR_NUM_SRC; g = g + 1) begin : g_src
			wire active = (bus.field[g] != `IPR_LEVEL_OFF);
			// codes map straight onto levels, 7 highest, 1 lowest
			assign bus.level[g] = bus.field[g]; // R1 R2 R4 R13
			// zero code disables, enable bit gates the source
			assign bus.req[g] = bus.src[g] & bus.enable[g] & active; // R3 R12

			off_no_req_a : assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R3
				(bus.field[g] == `IPR_LEVEL_OFF) |-> !bus.req[g])
				else $error("disabled source raised a request");
			en_gate_a : assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R12
				(bus.src[g] && bus.field[g] != `IPR_LEVEL_OFF) |-> (bus.req[g] == bus.enable[g]))
				else $error("enable bit did not gate the request");
			top_level_a : assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R1
				(bus.field[g] == `IPR_LEVEL_MAX) |-> (bus.level[g] == 3'h7))
				else $error("all-ones code is not level seven");
			low_level_a : assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R2
				(bus.field[g] == `IPR_LEVEL_MIN) |-> (bus.level[g] == 3'h1))
				else $error("code one is not level one");
		end
	endgenerate
endmodule : ipr_level_dec

//--- ipr_regs.sv
// priority control registers behind an avalon-mm slave
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ipr_defs.svh"
// Contract
// R1 - code 111 means level 7, highest
// R2 - code 001 means level 1, lowest
// R3 - code 000 disables the source
// R4 - codes 010..110 map linearly to 2..6
// R5 - unassigned bits ignore writes, read zero
// R6 - fields reset to 100, all read/write
// R7 - reg0: timer1, outcmp1, incap1, extirq0
// R8 - reg1: timer2, outcmp2, incap2, dma0
// R9 - reg2: uart rx, spi event, spi error, timer3
// R10 - reg3: bits 15-11 empty, dma1, adc, uart tx
// R11 - reg4: pin change, bits 11-7 empty, i2c
// R12 - per-source enable bit gates the request
// R13 - levels driven combinationally from stored fields
module ipr_regs (
	input  wire logic        I_CLK,
	input  wire logic        I_RSTN,
	input  wire logic [4:0]  I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [31:0] I_AVS_WRITEDATA,
	input  wire logic [3:0]  I_AVS_BYTEENABLE,
	output logic      [31:0] O_AVS_READDATA,
	output wire logic        O_AVS_WAITREQUEST,
	input  wire logic [17:0] I_SRC_REQ,
	output wire logic [53:0] O_LEVEL,
	output wire logic [17:0] O_REQ
);
	// slot of each source: register * 4 + position from the top field
	localparam int SRC_SLOT [18] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 13, 14, 15, 16, 18, 19};

	ipr_prio_if u_link ();

	ipr_pkg::ipr_word_t    prio [`IPR_NUM_REGS];
	ipr_pkg::ipr_src_vec_t enable;
	logic                  ack;

	// byte enables widened to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : lane_mask

	// implemented field bits of each priority register
	function automatic ipr_pkg::ipr_word_t impl_mask(input int r);
		impl_mask = (r == 3) ? `IPR_MASK_REG3 : (r == 4) ? `IPR_MASK_REG4 : `IPR_MASK_FULL;
	endfunction : impl_mask

	wire        access   = I_AVS_READ | I_AVS_WRITE;
	wire [2:0]  idx      = I_AVS_ADDRESS[4:2];
	wire        wr_fire  = I_AVS_WRITE & ack;
	wire [31:0] wr_mask  = lane_mask(I_AVS_BYTEENABLE);

	// one wait cycle on every access
	assign O_AVS_WAITREQUEST = access & ~ack;

	always_ff @(posedge I_CLK) begin
		if (!I_RSTN)
			ack <= 1'b0;
		else
			ack <= access & ~ack;
	end

	genvar r;
	genvar s;

	generate
		for (r = 0; r < `IPR_NUM_REGS; r = r + 1) begin : g_reg
			wire                sel       = wr_fire && (idx == 3'(r));
			wire [15:0]         wmask     = wr_mask[15:0] & impl_mask(r);
			ipr_pkg::ipr_word_t next_prio;
			// unassigned bits never load
			assign next_prio = (prio[r] & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask); // R5
			always_ff @(posedge I_CLK) begin
				if (!I_RSTN)
					prio[r] <= `IPR_FIELD_RST & impl_mask(r); // R6
				else if (sel)
					prio[r] <= next_prio; // R6
			end
		end

		// field extraction, top field first within each register
		for (s = 0; s < `IPR_NUM_SRC; s = s + 1) begin : g_field
			localparam int RI  = SRC_SLOT[s] / `IPR_SLOTS_PER_REG;
			localparam int LSB = `IPR_TOP_LSB - `IPR_SLOT_STRIDE * (SRC_SLOT[s] % `IPR_SLOTS_PER_REG);
			assign u_link.field[s] = prio[RI][LSB +: `IPR_FIELD_W]; // R7 R8 R9 R10 R11
			assign O_LEVEL[s*3 +: 3] = u_link.level[s]; // R13

			field_pos_a : assert property (@(posedge I_CLK) disable iff (!I_RSTN) // R7 R8 R9 R10 R11
				(wr_fire && idx == 3'(RI) && I_AVS_BYTEENABLE[LSB / 8]) |=>
				(O_LEVEL[s*3 +: 3] == $past(I_AVS_WRITEDATA[LSB +: 3])))
				else $error("priority field not at its bit position");
		end
	endgenerate

	wire en_sel = wr_fire && (idx == `IPR_IDX_ENABLE);
	ipr_pkg::ipr_src_vec_t next_enable;
	assign next_enable = (enable & ~wr_mask[17:0]) | (I_AVS_WRITEDATA[17:0] & wr_mask[17:0]);

	always_ff @(posedge I_CLK) begin
		if (!I_RSTN)
			enable <= `IPR_ENABLE_RST;
		else if (en_sel)
			enable <= next_enable; // R12
	end

	assign u_link.enable = enable;
	assign u_link.src    = I_SRC_REQ;
	assign O_REQ         = u_link.req;

	ipr_level_dec u_dec (
		.I_CLK  (I_CLK),
		.I_RSTN (I_RSTN),
		.bus    (u_link)
	);

	// read selection; unmapped words read zero
	wire        is_prio  = (idx <= `IPR_IDX_PRIO4);
	wire [31:0] prio_rd  = is_prio ? {16'h0000, prio[idx]} : 32'h0000_0000; // R5
	wire [31:0] en_rd    = (idx == `IPR_IDX_ENABLE) ? {14'h0, enable} : 32'h0000_0000;
	wire [31:0] pend_rd  = (idx == `IPR_IDX_PENDING) ? {14'h0, u_link.req} : 32'h0000_0000;
	wire [31:0] rd_word  = prio_rd | en_rd | pend_rd;

	always_ff @(posedge I_CLK) begin
		if (!I_RSTN)
			O_AVS_READDATA <= 32'h0000_0000;
		else if (I_AVS_READ && !ack)
			O_AVS_READDATA <= rd_word;
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);

	one_wait_a : assert property ((access && !ack) |=> (ack && !O_AVS_WAITREQUEST))
		else $error("access not answered after one wait cycle");

	reset_value_a : assert property (@(posedge I_CLK) disable iff (1'b0) // R6
		!I_RSTN |=> (prio[0] == 16'h4444 && prio[3] == 16'h0444 && prio[4] == 16'h4044))
		else $error("priority fields not reset to level four");

	reg3_gap_a : assert property ((prio[3] & 16'hF888) == 16'h0000) // R10
		else $error("unassigned bits set in register three");

	reg4_gap_a : assert property ((prio[4] & 16'h8F88) == 16'h0000) // R11
		else $error("unassigned bits set in register four");

	gap_read_a : assert property ((I_AVS_READ && !ack && is_prio) |=> // R5
		((O_AVS_READDATA & 32'hFFFF_8888) == 32'h0000_0000))
		else $error("unassigned bits read nonzero");

	timer1_write_a : assert property ((wr_fire && idx == `IPR_IDX_PRIO0 && I_AVS_BYTEENABLE[1]) |=> // R7
		(O_LEVEL[2:0] == $past(I_AVS_WRITEDATA[14:12])))
		else $error("timer1 field not at bits 14-12");

	dma0_write_a : assert property ((wr_fire && idx == `IPR_IDX_PRIO1 && I_AVS_BYTEENABLE[0]) |=> // R8
		(O_LEVEL[23:21] == $past(I_AVS_WRITEDATA[2:0])))
		else $error("dma0 field not at bits 2-0");

	spi_err_write_a : assert property ((wr_fire && idx == `IPR_IDX_PRIO2 && I_AVS_BYTEENABLE[0]) |=> // R9
		(O_LEVEL[32:30] == $past(I_AVS_WRITEDATA[6:4])))
		else $error("spi error field not at bits 6-4");

	i2c_slave_write_a : assert property ((wr_fire && idx == `IPR_IDX_PRIO4 && I_AVS_BYTEENABLE[0]) |=> // R11
		(O_LEVEL[53:51] == $past(I_AVS_WRITEDATA[2:0])))
		else $error("i2c slave field not at bits 2-0");

	hold_level_a : assert property ((!wr_fire) |=> $stable(O_LEVEL)) // R13
		else $error("level changed without a write");

	ladder_a : assert property ((O_LEVEL[2:0] > O_LEVEL[5:3]) |-> (prio[0][14:12] > prio[0][10:8])) // R4
		else $error("level order differs from code order");

	rd_hold_a : assert property (!(I_AVS_READ && !ack) |=> $stable(O_AVS_READDATA)) // R5
		else $error("read data changed outside a read");

	en_write_a : assert property ((wr_fire && idx == `IPR_IDX_ENABLE && I_AVS_BYTEENABLE[0]) |=> // R12
		(enable[7:0] == $past(I_AVS_WRITEDATA[7:0])))
		else $error("enable bits not loaded by a write");

endmodule : ipr_regs

//--- ipr_src_model.sv
// request sources on the far side of the priority block
`timescale 1ns/1ps
module ipr_src_model (
	input  wire logic        i_clk,
	input  wire logic [17:0] i_next,
	output logic      [17:0] o_req
);
	// level requests change only on the clock edge
	always_ff @(posedge i_clk) begin
		o_req <= i_next;
	end
endmodule : ipr_src_model

//--- ipr_regs_tb.sv
// self-checking bench for the priority register block
`timescale 1ns/1ps
module ipr_regs_tb;
	logic        I_CLK = 1'b0;
	logic        I_RSTN = 1'b0;
	logic [4:0]  adr = 5'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0]  be = 4'hF;
	logic [31:0] rdat;
	logic        wait_req;
	logic [17:0] src_next = 18'h0;
	logic [17:0] src;
	logic [53:0] lvl;
	logic [17:0] req;
	logic [31:0] q;
	logic [4:0]  ra;
	int          err_count = 0;
	int          checked = 0;
	int          seed = 57075;
	logic [31:0] mreg [8] = '{32'h4444, 32'h4444, 32'h4444, 32'h0444, 32'h4044, 32'h0, 32'h0, 32'h0};
	logic [31:0] mask [8] = '{32'h7777, 32'h7777, 32'h7777, 32'h0777, 32'h7077, 32'h3FFFF, 32'h0, 32'h0};

	always #2.5 I_CLK = ~I_CLK;

	ipr_regs dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
		.I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wait_req),
		.I_SRC_REQ(src), .O_LEVEL(lvl), .O_REQ(req));
	ipr_src_model src_m (.i_clk(I_CLK), .i_next(src_next), .o_req(src));

	function automatic logic [53:0] exp_lvl();
		logic [53:0] v;
		int          s;
		v = '0;
		s = 0;
		for (int r = 0; r < 5; r++) for (int b = 12; b >= 0; b -= 4) if (mask[r][b]) begin
			v[3*s +: 3] = mreg[r][b +: 3];
			s++;
		end
		return v;
	endfunction : exp_lvl

	function automatic logic [17:0] exp_req();
		logic [53:0] l;
		logic [17:0] v;
		l = exp_lvl();
		for (int s = 0; s < 18; s++) v[s] = src[s] & mreg[5][s] & (l[3*s +: 3] != 3'h0);
		return v;
	endfunction : exp_req

	task automatic chk(input logic [53:0] seen, input logic [53:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic test_done();
		$display("mismatches %0d comparisons %0d", err_count, checked);
		if (err_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done

	// one avalon access, held until waitrequest is seen low
	task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] e);
		int          n;
		logic [31:0] bm;
		n = 0;
		bm = {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
		@(posedge I_CLK);
		adr <= a;
		wdat <= d;
		be <= e;
		wr <= w;
		rd <= !w;
		@(posedge I_CLK);
		while (wait_req !== 1'b0 && n < 20) begin
			@(posedge I_CLK);
			n++;
		end
		if (wait_req !== 1'b0) begin
			err_count++;
			test_done();
		end
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (w) mreg[a[4:2]] = (mreg[a[4:2]] & ~bm) | (d & bm & mask[a[4:2]]);
		else chk(54'(q), 54'(a[4:2] == 3'h6 ? 32'(exp_req()) : mreg[a[4:2]]));
	endtask : acc

	task automatic look();
		@(negedge I_CLK);
		chk(lvl, exp_lvl());
		chk(54'(req), 54'(exp_req()));
	endtask : look

	initial begin
		repeat (2) @(posedge I_CLK);
		I_RSTN <= 1'b1;
		for (int i = 0; i < 8; i++) acc(1'b0, 5'(i * 4), 32'h0, 4'hF);
		look();
		acc(1'b1, 5'h14, 32'h3FFFF, 4'hF);
		for (int c = 0; c < 8; c++) begin
			src_next <= 18'(c * 37449);
			for (int r = 0; r < 5; r++) acc(1'b1, 5'(r * 4), 32'(c * 16'h1111), 4'hF);
			look();
		end
		repeat (60) begin
			src_next <= 18'($random(seed));
			ra = 5'($random(seed));
			acc(1'b1, ra, $random(seed), 4'($random(seed)));
			acc(1'b0, ra, 32'h0, 4'hF);
			look();
		end
		@(posedge I_CLK);
		I_RSTN <= 1'b0;
		repeat (2) @(posedge I_CLK);
		I_RSTN <= 1'b1;
		mreg = '{32'h4444, 32'h4444, 32'h4444, 32'h0444, 32'h4044, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 8; i++) acc(1'b0, 5'(i * 4), 32'h0, 4'hF);
		look();
		test_done();
	end
endmodule : ipr_regs_tb
